// [eesfr_top.sv]
// sfr interface, sequencer and array of the on-chip eeprom
`timescale 1ns/1ps

module eesfr_top #(
  parameter int DEPTH = 256,
  parameter int SEC_BITS = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic completion_irq
);
  import eesfr_pkg::*;

  // ==========================================================
  // storage
  logic [7:0] eeprom_address_low;
  logic [7:0] eeprom_address_high;
  logic [7:0] eeprom_data_port;
  logic [7:0] program_time_prescale;
  logic completion_interrupt_flag;
  logic completion_interrupt_enable;
  logic program_in_progress;
  logic [3:0] op_code;
  logic [7:0] mem [DEPTH];
  logic [SEC_BITS-1:0] sec_bits;
  eesfr_state_t state;
  logic [7:0] div_cnt;
  logic tick;
  logic [8:0] tick_cnt;
  logic [7:0] lat_addr;
  logic [7:0] lat_data;
  logic [3:0] lat_op;
  logic lat_sec;
  logic pulse_done;

  // ==========================================================
  // decode
  logic wr_low, wr_high, wr_data, wr_pre, wr_ctl, rd_data;
  logic start_op, op_legal, sec_sel;
  assign sec_sel = eeprom_address_high[7];
  // busy blocks every sfr write except to the control flags
  assign wr_low = sfr_wr && sfr_addr == EESFR_ADDR_LOW
    && !program_in_progress;
  assign wr_high = sfr_wr && sfr_addr == EESFR_ADDR_HIGH
    && !program_in_progress;
  assign wr_data = sfr_wr && sfr_addr == EESFR_DATA
    && !program_in_progress;
  assign wr_pre = sfr_wr && sfr_addr == EESFR_PRESCALE
    && !program_in_progress;
  assign wr_ctl = sfr_wr && sfr_addr == EESFR_CONTROL;
  assign rd_data = sfr_rd && sfr_addr == EESFR_DATA
    && !program_in_progress;
  // page codes are reserved and launch nothing
  assign op_legal = op_code == EESFR_OP_BYTE
    || op_code == EESFR_OP_ROW_ERASE
    || op_code == EESFR_OP_BLOCK_ERASE;
  assign start_op = wr_data && op_legal;

  // ==========================================================
  // address and prescale registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eeprom_address_low <= EESFR_ADDR_LOW_RST;
      eeprom_address_high <= EESFR_ADDR_HIGH_RST;
      program_time_prescale <= EESFR_PRESCALE_RST;
    end else begin
      if (wr_low) begin
        eeprom_address_low <= sfr_wdata;
      end
      if (wr_high) begin
        eeprom_address_high <= sfr_wdata;
      end
      if (wr_pre) begin
        program_time_prescale <= sfr_wdata;
      end
    end
  end

  // ==========================================================
  // data register: cpu writes load it, every non-busy cycle without a write refreshes it from the array or, with sec_sel set, from the security bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eeprom_data_port <= 8'h00;
    end else if (wr_data) begin
      eeprom_data_port <= sfr_wdata;
    end else if (!program_in_progress) begin
      // tracks the addressed byte so a read sees it at once
      eeprom_data_port <= sec_sel
        ? {{(8-1){1'b0}}, sec_bits[eeprom_address_low[2:0]]}
        : mem[eeprom_address_low];
    end
  end

  // ==========================================================
  // control register; completion set wins over software clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      completion_interrupt_flag <= EESFR_CONTROL_RST[EESFR_IRQ_FLAG_BIT];
      completion_interrupt_enable <= EESFR_CONTROL_RST[EESFR_IRQ_EN_BIT];
      op_code <= EESFR_CONTROL_RST[3:0];
    end else begin
      if (wr_ctl) begin
        completion_interrupt_flag <= sfr_wdata[EESFR_IRQ_FLAG_BIT];
        completion_interrupt_enable <= sfr_wdata[EESFR_IRQ_EN_BIT];
        if (!program_in_progress) begin
          op_code <= sfr_wdata[3:0];
        end
      end
      if (pulse_done) begin
        completion_interrupt_flag <= 1'b1;
      end
    end
  end

  // ==========================================================
  // prescale divider: one tick every EESFR_TICK_DIV core clocks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (state == EESFR_IDLE) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick <= div_cnt == 8'(EESFR_TICK_DIV - 1);
    end
  end

  // ==========================================================
  // sequencer: byte mode erases then writes, erases stop after one
  // pulse; pulse length is (prescale + 2) ticks
  assign pulse_done = tick && tick_cnt == 9'h001
    && (state == EESFR_WRITE
      || (state == EESFR_ERASE && lat_op != EESFR_OP_BYTE));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= EESFR_IDLE;
      tick_cnt <= 9'h000;
      program_in_progress <= 1'b0;
      lat_addr <= 8'h00;
      lat_data <= 8'h00;
      lat_op <= 4'h0;
      lat_sec <= 1'b0;
    end else begin
      unique case (state)
        EESFR_IDLE: begin
          if (start_op) begin
            state <= EESFR_ERASE;
            program_in_progress <= 1'b1;
            tick_cnt <= {1'b0, program_time_prescale}
              + EESFR_TICK_OFFSET;
            lat_addr <= eeprom_address_low;
            lat_data <= sfr_wdata;
            lat_op <= op_code;
            lat_sec <= sec_sel;
          end
        end
        EESFR_ERASE: begin
          if (tick) begin
            tick_cnt <= tick_cnt - 9'h001;
            if (tick_cnt == 9'h001) begin
              if (lat_op == EESFR_OP_BYTE) begin
                state <= EESFR_WRITE;
                tick_cnt <= {1'b0, program_time_prescale}
                  + EESFR_TICK_OFFSET;
              end else begin
                state <= EESFR_IDLE;
                program_in_progress <= 1'b0;
              end
            end
          end
        end
        EESFR_WRITE: begin
          if (tick) begin
            tick_cnt <= tick_cnt - 9'h001;
            if (tick_cnt == 9'h001) begin
              state <= EESFR_IDLE;
              program_in_progress <= 1'b0;
            end
          end
        end
        default: begin
          state <= EESFR_IDLE;
          program_in_progress <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // array update at the end of each pulse unless lat_sec selects the security bits; no reset on contents
  logic erase_end;
  assign erase_end = tick && tick_cnt == 9'h001 && state == EESFR_ERASE;
  always_ff @(posedge clk) begin
    if (erase_end && !lat_sec) begin
      if (lat_op == EESFR_OP_BLOCK_ERASE) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem[i] <= 8'h00;
        end
      end else if (lat_op == EESFR_OP_ROW_ERASE) begin
        for (int i = 0; i < 8; i++) begin
          mem[{lat_addr[7:3], 3'(i)}] <= 8'h00;
        end
      end else begin
        mem[lat_addr] <= 8'h00;
      end
    end else if (pulse_done && state == EESFR_WRITE && !lat_sec) begin
      mem[lat_addr] <= lat_data;
    end
  end

  // security bits live in flops so block erase can clear them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_bits <= '0;
    end else if (erase_end && lat_op == EESFR_OP_BLOCK_ERASE) begin
      sec_bits <= '0;
    end else if (pulse_done && state == EESFR_WRITE && lat_sec) begin
      sec_bits[lat_addr[2:0]] <= lat_data[0];
    end
  end

  // ==========================================================
  // read mux, registered; unmapped addresses answer zero, no hit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end else begin
      sfr_hit <= sfr_rd && sfr_addr >= EESFR_ADDR_LOW
        && sfr_addr <= EESFR_CONTROL;
      unique case (sfr_addr)
        EESFR_ADDR_LOW: sfr_rdata <= eeprom_address_low;
        EESFR_ADDR_HIGH: sfr_rdata <= eeprom_address_high;
        EESFR_DATA: sfr_rdata <= rd_data ? eeprom_data_port : 8'h00;
        EESFR_PRESCALE: sfr_rdata <= program_time_prescale;
        EESFR_CONTROL: sfr_rdata <= {completion_interrupt_flag,
          completion_interrupt_enable, program_in_progress, 1'b0,
          op_code};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // interrupt request to the core's shared vector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      completion_irq <= 1'b0;
    end else begin
      completion_irq <= completion_interrupt_flag
        && completion_interrupt_enable;
    end
  end
endmodule

// [eesfr_pkg.sv]
// constants for the eeprom special function register interface
package eesfr_pkg;
  // register addresses on the sfr bus
  localparam logic [7:0] EESFR_ADDR_LOW = 8'hF2;
  localparam logic [7:0] EESFR_ADDR_HIGH = 8'hF3;
  localparam logic [7:0] EESFR_DATA = 8'hF4;
  localparam logic [7:0] EESFR_PRESCALE = 8'hF5;
  localparam logic [7:0] EESFR_CONTROL = 8'hF6;
  // reset values
  localparam logic [7:0] EESFR_ADDR_HIGH_RST = 8'h80;
  localparam logic [7:0] EESFR_ADDR_LOW_RST = 8'h00;
  localparam logic [7:0] EESFR_PRESCALE_RST = 8'h08;
  localparam logic [7:0] EESFR_CONTROL_RST = 8'h00;
  // control field positions
  localparam int EESFR_IRQ_FLAG_BIT = 7;
  localparam int EESFR_IRQ_EN_BIT = 6;
  localparam int EESFR_BUSY_BIT = 5;
  // operation codes in the low nibble
  localparam logic [3:0] EESFR_OP_BYTE = 4'h0;
  localparam logic [3:0] EESFR_OP_ROW_ERASE = 4'hC;
  localparam logic [3:0] EESFR_OP_BLOCK_ERASE = 4'h9;
  // one prescale tick spans this many core clocks
  localparam int EESFR_TICK_DIV = 256;
  // prescale ticks per pulse: prescale value plus this offset
  localparam logic [8:0] EESFR_TICK_OFFSET = 9'h002;
  typedef enum logic [1:0] {
    EESFR_IDLE = 2'b00,
    EESFR_ERASE = 2'b01,
    EESFR_WRITE = 2'b10
  } eesfr_state_t;
endpackage

// [eesfr_asserts.sv]
// port assertions for the eeprom sfr interface
`timescale 1ns/1ps
module eesfr_asserts
  import eesfr_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int SEC_BITS = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic completion_irq
);
  logic map;
  logic f3_w;
  logic f5_w;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign map = sfr_addr >= EESFR_ADDR_LOW && sfr_addr <= EESFR_CONTROL;
  // reset values only hold until software first writes the register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      f3_w <= 1'b0;
      f5_w <= 1'b0;
    end else begin
      f3_w <= f3_w | (sfr_wr && sfr_addr == EESFR_ADDR_HIGH);
      f5_w <= f5_w | (sfr_wr && sfr_addr == EESFR_PRESCALE);
    end
  end
  // =========================================
  // interrupt steps
  sequence irq_seen;
    completion_irq && sfr_rd && sfr_addr == EESFR_CONTROL && !sfr_wr &&
      !$past(sfr_wr);
  endsequence
  sequence en_clear;
    sfr_wr && sfr_addr == EESFR_CONTROL && !sfr_wdata[6];
  endsequence
  map_hit_a: assert property (sfr_rd && map |=> sfr_hit)
    else $error("mapped read gave no hit");
  unmapped_quiet_a: assert property (sfr_rd && !map |=>
    !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped read answered");
  idle_hit_a: assert property (!sfr_rd |=> !sfr_hit)
    else $error("hit without read");
  prescale_reset_a: assert property (sfr_rd && sfr_addr == EESFR_PRESCALE
    && !f5_w |=> sfr_rdata == 8'h08)
    else $error("prescale reset value wrong");
  high_reset_a: assert property (sfr_rd && sfr_addr == EESFR_ADDR_HIGH &&
    !f3_w |=> sfr_rdata == 8'h80)
    else $error("high address reset value wrong");
  irq_clear_a: assert property (en_clear |-> ##[1:2] !completion_irq)
    else $error("irq stays with enable cleared");
  irq_source_a: assert property (irq_seen |=> sfr_rdata[7:6] == 2'b11)
    else $error("irq without flag and enable");
  reset_quiet_a: assert property ($rose(rstn) |->
    !sfr_hit && !completion_irq) else $error("outputs busy after reset");
endmodule
bind eesfr_top eesfr_asserts #(.DEPTH(DEPTH), .SEC_BITS(SEC_BITS)) u_chk (
  .clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit), .completion_irq(completion_irq));

// [eesfr_cpu_model.sv]
// behavioural cpu core driving the eeprom sfr bus
`timescale 1ns/1ps
module eesfr_cpu_model (
  input wire logic clk,
  output logic [7:0] sfr_addr = 8'h00,
  output logic [7:0] sfr_wdata = 8'h00,
  output logic sfr_wr = 1'b0,
  output logic sfr_rd = 1'b0,
  input wire logic [7:0] sfr_rdata
);
  // =========================================
  // one-cycle write strobe, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    sfr_wdata = ~d; // released bus must not show stale data
  endtask
  // read data arrives the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1;
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
endmodule

// [test_eesfr_top.sv]
// self-checking bench for the eeprom sfr interface
`timescale 1ns/1ps
module test_eesfr_top;
  import eesfr_pkg::*;
  typedef struct packed {logic [7:0] d; logic [7:0] m; logic h;} eesfr_note_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, a, d;
  logic sfr_wr, sfr_rd, sfr_hit, completion_irq, rd_q = 1'b0;
  int fail_count = 0, compares = 0, cycles = 0, seed = 32'h4ddf;
  eesfr_note_t q[$];
  eesfr_note_t n;
  eesfr_top dut (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .completion_irq(completion_irq));
  eesfr_cpu_model cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));
  always #10 clk = ~clk;
  // =========================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // note the expected answer, then read
  task automatic rd(input logic [7:0] ad, input logic [7:0] e,
                    input logic [7:0] m);
    logic [7:0] v;
    q.push_back('{e, m, ad >= EESFR_ADDR_LOW && ad <= EESFR_CONTROL});
    cpu.rd(ad, v);
  endtask
  task automatic op(input logic [7:0] ad, input logic [7:0] c,
                    input logic [7:0] dd);
    cpu.wr(EESFR_ADDR_LOW, ad);
    cpu.wr(EESFR_CONTROL, c);
    cpu.wr(EESFR_DATA, dd);
  endtask
  // bounded poll of the busy flag
  task automatic wait_idle();
    logic [7:0] v = 8'hFF;
    for (int i = 0; i < 3000 && v[5]; i++) begin
      q.push_back('{8'h00, 8'h00, 1'b1});
      cpu.rd(EESFR_CONTROL, v);
    end
    // a sequencer stuck busy past the poll limit counts as a miss
    chk(v & 8'h20, 8'h00);
  endtask
  // =========================================
  // watcher: a read answers one cycle after its edge
  always @(posedge clk) begin
    if (rd_q) begin
      n = q.pop_front();
      chk(sfr_rdata & n.m, n.d & n.m);
      chk({7'h00, sfr_hit}, {7'h00, n.h});
    end
    rd_q <= sfr_rd;
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    rd(EESFR_ADDR_LOW, 8'h00, 8'hFF);
    rd(EESFR_ADDR_HIGH, 8'h80, 8'hFF);
    rd(EESFR_PRESCALE, 8'h08, 8'hFF);
    rd(EESFR_CONTROL, 8'h00, 8'hFF);
    rd(8'hF7, 8'h00, 8'hFF);
    cpu.wr(EESFR_ADDR_HIGH, 8'h00);
    rd(EESFR_ADDR_HIGH, 8'h00, 8'hFF);
    cpu.wr(EESFR_PRESCALE, 8'h00); // shortest legal pulse here
    rd(EESFR_PRESCALE, 8'h00, 8'hFF);
    // byte write with irq on; busy refuses access meanwhile
    a = 8'($random(seed));
    d = 8'($random(seed));
    op(a, 8'h40, d);
    cpu.wr(EESFR_ADDR_LOW, ~a);
    rd(EESFR_DATA, 8'h00, 8'hFF);
    wait_idle();
    rd(EESFR_CONTROL, 8'hC0, 8'hE0);
    rd(EESFR_ADDR_LOW, a, 8'hFF);
    rd(EESFR_DATA, d, 8'hFF);
    chk({7'h00, completion_irq}, 8'h01);
    cpu.wr(EESFR_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    chk({7'h00, completion_irq}, 8'h00);
    repeat (3) begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      op(a, 8'h00, d);
      wait_idle();
      rd(EESFR_DATA, d, 8'hFF);
    end
    op(8'h2B, 8'h00, 8'h5A);
    wait_idle();
    op(8'h33, 8'h00, 8'hA5);
    wait_idle();
    op(8'h2D, 8'h0C, 8'h77); // row erase, data ignored
    wait_idle();
    cpu.wr(EESFR_ADDR_LOW, 8'h2B);
    rd(EESFR_DATA, 8'h00, 8'hFF);
    cpu.wr(EESFR_ADDR_LOW, 8'h33);
    rd(EESFR_DATA, 8'hA5, 8'hFF);
    op(8'h10, 8'h03, 8'h11); // page code starts nothing
    rd(EESFR_CONTROL, 8'h00, 8'h20);
    // security bit 3 reached through the high address select
    cpu.wr(EESFR_ADDR_HIGH, 8'h80);
    op(8'h03, 8'h00, 8'h01);
    wait_idle();
    rd(EESFR_DATA, 8'h01, 8'hFF);
    cpu.wr(EESFR_ADDR_HIGH, 8'h00);
    op(8'h10, 8'h09, 8'h11); // block erase
    wait_idle();
    cpu.wr(EESFR_ADDR_LOW, 8'h33);
    rd(EESFR_DATA, 8'h00, 8'hFF);
    // block erase clears the security bits as well
    cpu.wr(EESFR_ADDR_HIGH, 8'h80);
    cpu.wr(EESFR_ADDR_LOW, 8'h03);
    rd(EESFR_DATA, 8'h00, 8'hFF);
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule
